// >>> src/ccd_pkg.sv
// Shared constants and types for the channel clock divider block.
// Assumes a single 10 MHz system clock and a byte-wide register space.
package ccd_pkg;

    // Register space geometry: each printed offset is a word index.
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int NUM_REGS = 17;

    // Printed register indexes, in slot order of the configuration array.
    localparam logic [9:0] IDX_DIV0_CYCLE_COUNTS = 10'h190;
    localparam logic [9:0] IDX_DIV0_BYPASS_OFFSET = 10'h191;
    localparam logic [9:0] IDX_DIV0_DUTY_CTRL = 10'h192;
    localparam logic [9:0] IDX_DIV1_CYCLE_COUNTS = 10'h193;
    localparam logic [9:0] IDX_DIV1_BYPASS_OFFSET = 10'h194;
    localparam logic [9:0] IDX_DIV1_DUTY_CTRL = 10'h195;
    localparam logic [9:0] IDX_DIV2_CYCLE_COUNTS = 10'h196;
    localparam logic [9:0] IDX_DIV2_BYPASS_OFFSET = 10'h197;
    localparam logic [9:0] IDX_DIV2_DUTY_CTRL = 10'h198;
    localparam logic [9:0] IDX_DIV3_STAGE1_COUNTS = 10'h199;
    localparam logic [9:0] IDX_DIV3_STAGE2_COUNTS = 10'h19b;
    localparam logic [9:0] IDX_DIV3_STAGE_BYPASS = 10'h19c;
    localparam logic [9:0] IDX_DIV3_DUTY_CTRL = 10'h19d;
    localparam logic [9:0] IDX_DIV4_STAGE1_COUNTS = 10'h19e;
    localparam logic [9:0] IDX_DIV4_STAGE2_COUNTS = 10'h1a0;
    localparam logic [9:0] IDX_DIV4_STAGE_BYPASS = 10'h1a1;
    localparam logic [9:0] IDX_DIV4_DUTY_CTRL = 10'h1a2;
    localparam logic [9:0] REG_IDX [NUM_REGS] = '{
        IDX_DIV0_CYCLE_COUNTS, IDX_DIV0_BYPASS_OFFSET, IDX_DIV0_DUTY_CTRL,
        IDX_DIV1_CYCLE_COUNTS, IDX_DIV1_BYPASS_OFFSET, IDX_DIV1_DUTY_CTRL,
        IDX_DIV2_CYCLE_COUNTS, IDX_DIV2_BYPASS_OFFSET, IDX_DIV2_DUTY_CTRL,
        IDX_DIV3_STAGE1_COUNTS, IDX_DIV3_STAGE2_COUNTS, IDX_DIV3_STAGE_BYPASS,
        IDX_DIV3_DUTY_CTRL, IDX_DIV4_STAGE1_COUNTS, IDX_DIV4_STAGE2_COUNTS,
        IDX_DIV4_STAGE_BYPASS, IDX_DIV4_DUTY_CTRL};

    // Extra control and status registers.
    localparam logic [9:0] IDX_SYNC_CTRL = 10'h1a8;
    localparam logic [9:0] IDX_PRESCALE = 10'h1a9;
    localparam logic [9:0] IDX_B_ENABLE = 10'h1aa;
    localparam logic [9:0] IDX_OUT_STATUS = 10'h1ab;

    // Slot layout inside the configuration array.
    localparam int SLOTS_PER_SINGLE = 3;
    localparam int SLOT_CASCADE_BASE = 9;
    localparam int SLOTS_PER_CASCADE = 4;

    // Field positions.
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 4;
    localparam int HIGH_MSB = 3;
    localparam int HIGH_LSB = 0;
    localparam int BYPASS_BIT = 7;
    localparam int START_HIGH_BIT = 4;
    localparam int OFFSET_MSB = 3;
    localparam int OFFSET_LSB = 0;
    localparam int DUTY_FIX_DISABLE_BIT = 0;
    localparam int DIRECT_OUT_BIT = 1;
    localparam int STAGE1_BYPASS_BIT = 4;
    localparam int STAGE2_BYPASS_BIT = 5;
    localparam int SYNC_BIT = 0;
    localparam int PRESCALE_MSB = 2;

    // Reset values.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] PRESCALE_RESET = 3'h2;
    localparam logic [1:0] B_ENABLE_RESET = 2'h0;

    // Pre-divider limits.
    localparam logic [2:0] PRESCALE_MIN = 3'h2;
    localparam logic [2:0] PRESCALE_MAX = 3'h6;

    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_HIGH, ST_HALF, ST_LOW} ccd_stage_state_t;

endpackage

// >>> src/ccd_stage.sv
// One 2-to-32 divider stage working on rise and fall strobes of its input clock.
// Assumes the strobes come from flip-flops and never rise and fall in one cycle.
module ccd_stage (
    input wire logic sys_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic sync, // One-cycle output synchronisation event.
    input wire logic in_rise, // Input clock rising-edge strobe.
    input wire logic in_fall, // Input clock falling-edge strobe.
    input wire logic in_level, // Input clock level.
    input wire logic bypass, // Pass the input through.
    input wire logic duty_fix_disable, // Turn off duty correction.
    input wire logic [3:0] low_cnt, // Low cycles minus one.
    input wire logic [3:0] high_cnt, // High cycles minus one.
    input wire logic [4:0] delay, // First-edge delay in input cycles.
    output logic out_rise, // Output rising-edge strobe.
    output logic out_fall, // Output falling-edge strobe.
    output logic out_level // Output clock level.
);
    ccd_pkg::ccd_stage_state_t state;
    logic [5:0] cnt;
    logic pend;
    logic [3:0] sh_m;
    logic [3:0] sh_n;
    logic sh_dcc_off;
    logic [4:0] sh_dly;

    // Settings only change on a sync, which restarts the stage and cuts a running period short.
    wire load = pend | sync;
    wire [5:0] ratio = 6'(sh_m) + 6'(sh_n) + 6'h02;
    wire [5:0] hi_len = sh_dcc_off ? 6'(sh_n) + 6'h01 : {1'b0, ratio[5:1]};
    wire half = !sh_dcc_off & ratio[0];
    wire [5:0] lo_left = ratio - hi_len - 6'h01;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ccd_pkg::ST_IDLE;
            cnt <= 6'h00;
            pend <= 1'b1;
            sh_m <= 4'h0;
            sh_n <= 4'h0;
            sh_dcc_off <= 1'b0;
            sh_dly <= 5'h00;
            out_rise <= 1'b0;
            out_fall <= 1'b0;
            out_level <= 1'b0;
        end else begin
            out_rise <= 1'b0;
            out_fall <= 1'b0;
            if (load) begin
                pend <= 1'b0;
                sh_m <= low_cnt;
                sh_n <= high_cnt;
                sh_dcc_off <= duty_fix_disable;
                sh_dly <= delay;
                cnt <= 6'(delay);
                out_level <= bypass ? in_level : 1'b0;
                state <= bypass ? ccd_pkg::ST_IDLE : ccd_pkg::ST_WAIT;
            end else begin
                unique case (state)
                    ccd_pkg::ST_IDLE: begin
                        out_level <= in_level;
                        out_rise <= in_rise;
                        out_fall <= in_fall;
                    end
                    ccd_pkg::ST_WAIT: begin
                        if (in_rise) begin
                            if (cnt == 6'h00) begin
                                state <= ccd_pkg::ST_HIGH;
                                out_level <= 1'b1;
                                out_rise <= 1'b1;
                                cnt <= hi_len - 6'h01;
                            end else begin
                                cnt <= cnt - 6'h01;
                            end
                        end
                    end
                    ccd_pkg::ST_HIGH: begin
                        if (in_rise) begin
                            if (cnt == 6'h00) begin
                                if (half) begin
                                    state <= ccd_pkg::ST_HALF;
                                end else begin
                                    state <= ccd_pkg::ST_LOW;
                                    out_level <= 1'b0;
                                    out_fall <= 1'b1;
                                    cnt <= lo_left;
                                end
                            end else begin
                                cnt <= cnt - 6'h01;
                            end
                        end
                    end
                    ccd_pkg::ST_HALF: begin
                        // Odd ratios end the high phase half an input cycle late.
                        if (in_fall) begin
                            state <= ccd_pkg::ST_LOW;
                            out_level <= 1'b0;
                            out_fall <= 1'b1;
                            cnt <= lo_left;
                        end
                    end
                    ccd_pkg::ST_LOW: begin
                        if (in_rise) begin
                            if (cnt == 6'h00) begin
                                state <= ccd_pkg::ST_HIGH;
                                out_level <= 1'b1;
                                out_rise <= 1'b1;
                                cnt <= hi_len - 6'h01;
                            end else begin
                                cnt <= cnt - 6'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Helper logic: input rises seen since the previous output edge.
    logic [5:0] seen;
    logic first;
    always_ff @(posedge sys_clk) begin
        if (rst || load) begin
            seen <= 6'h00;
            first <= 1'b1;
        end else begin
            seen <= (out_rise | out_fall) ? 6'(in_rise) : seen + 6'(in_rise);
            if (out_rise) begin
                first <= 1'b0;
            end
        end
    end

    sequence s_start;
        state == ccd_pkg::ST_WAIT && in_rise && cnt == 6'h00 && !load;
    endsequence

    a_start_edge: assert property (@(posedge sys_clk) disable iff (rst)
        s_start |=> out_rise && out_level)
        else $error("delayed first rising edge missing");
    a_first_delay: assert property (@(posedge sys_clk) disable iff (rst)
        (out_rise && first && state != ccd_pkg::ST_IDLE) |-> seen == 6'(sh_dly) + 6'h01)
        else $error("first rising edge at wrong delay");
    a_high_len: assert property (@(posedge sys_clk) disable iff (rst)
        (out_fall && sh_dcc_off && state != ccd_pkg::ST_IDLE) |-> seen == 6'(sh_n) + 6'h01)
        else $error("high phase length wrong");
    a_low_len: assert property (@(posedge sys_clk) disable iff (rst)
        (out_rise && !first && sh_dcc_off && state != ccd_pkg::ST_IDLE)
        |-> seen == 6'(sh_m) + 6'h01)
        else $error("low phase length wrong");
    a_even_half: assert property (@(posedge sys_clk) disable iff (rst)
        (out_fall && !sh_dcc_off && !ratio[0] && state != ccd_pkg::ST_IDLE)
        |-> seen == {1'b0, ratio[5:1]})
        else $error("corrected even ratio not half high");
    a_half_fall: assert property (@(posedge sys_clk) disable iff (rst)
        (state == ccd_pkg::ST_HALF && in_fall && !load) |=> out_fall && !out_level)
        else $error("odd corrected fall not on input fall");
    a_bypass_pass: assert property (@(posedge sys_clk) disable iff (rst)
        (state == ccd_pkg::ST_IDLE && !load) |=> out_level == $past(in_level)
        && out_rise == $past(in_rise))
        else $error("bypassed stage does not pass input");

endmodule

// >>> src/ccd_top.sv
// Channel clock dividers: three single-stage and two two-stage channels.
// Assumes an Avalon-MM master and that all divider clocks are strobes of sys_clk.
//
// Summary of operation
// - Stage output low for low field plus one, high for high field plus one.
// - Single-stage divides by one when bypassed, else by fields sum plus two.
// - All counts run on the clock feeding each divider stage.
// - Duty correction on after reset; per-channel disable bit turns it off.
// - Correction forces 50% duty; needs equal fields even, low one more odd.
// - Uncorrected, unbypassed high fraction is (high+1) over (sum+2).
// - Direct routing passes the source clock with its duty unchanged.
// - First rising edge of unbypassed channels 0 to 2 delayed by the 5-bit start-high and offset code.
// - Code up to 15 delays by code; from 16 by code minus 16 plus low plus one.
// - Channels 3 and 4 cascade two stages, ratio the product up to 1024.
// - Two-stage ratio one, either stage alone, or product of both by bypass.
// - One disable bit per two-stage channel turns correction off in both.
// - The B output of channels 3 and 4 is off after reset until enabled.
// - A pre-divider of 2 to 6 feeds the dividers; odd ratios skew duty.
module ccd_top (
    input wire logic sys_clk, // System clock, 10 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [ccd_pkg::ADDR_W-1:0] avs_address, // Byte address.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data, low byte used.
    input wire logic [3:0] avs_byteenable, // Byte enables.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Wait request.
    output logic [4:0] out_clk_a, // Channel clock outputs 0 to 4.
    output logic [1:0] out_clk_b // Second outputs of channels 3 and 4.
);
    logic [7:0] cfg [ccd_pkg::NUM_REGS];
    logic [2:0] prescale;
    logic [1:0] b_en;
    logic sync_pulse;
    logic [2:0] phase;
    logic base_rise;
    logic base_fall;
    logic base_level;

    // Bus decode.
    wire req = avs_read | avs_write;
    wire [ccd_pkg::IDX_W-1:0] word_idx = avs_address[ccd_pkg::ADDR_W-1:2];
    wire access = req & ~avs_waitrequest;
    wire wr_en = access & avs_write & avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];
    wire hit_sync = word_idx == ccd_pkg::IDX_SYNC_CTRL;
    wire hit_pre = word_idx == ccd_pkg::IDX_PRESCALE;
    wire hit_ben = word_idx == ccd_pkg::IDX_B_ENABLE;
    wire hit_stat = word_idx == ccd_pkg::IDX_OUT_STATUS;
    logic [ccd_pkg::NUM_REGS-1:0] hit;
    logic [7:0] rd_byte;

    // Every access takes exactly one wait cycle, which also lets readdata settle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (req && avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < ccd_pkg::NUM_REGS; gi++) begin : g_reg
            assign hit[gi] = word_idx == ccd_pkg::REG_IDX[gi];
            // Reset clears every field, so duty correction starts enabled.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    cfg[gi] <= ccd_pkg::REG_RESET;
                end else if (wr_en && hit[gi]) begin
                    cfg[gi] <= wbyte;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < ccd_pkg::NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_byte = cfg[i];
            end
        end
        if (hit_pre) begin
            rd_byte = {5'h00, prescale};
        end
        if (hit_ben) begin
            rd_byte = {6'h00, b_en};
        end
        if (hit_stat) begin
            rd_byte = {1'b0, out_clk_b, out_clk_a};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prescale <= ccd_pkg::PRESCALE_RESET;
            b_en <= ccd_pkg::B_ENABLE_RESET;
            sync_pulse <= 1'b0;
        end else begin
            sync_pulse <= wr_en & hit_sync & wbyte[ccd_pkg::SYNC_BIT];
            if (wr_en && hit_pre) begin
                prescale <= wbyte[ccd_pkg::PRESCALE_MSB:0];
            end
            if (wr_en && hit_ben) begin
                b_en <= wbyte[1:0];
            end
        end
    end

    // Pre-divider: out-of-range codes fall back to the smallest ratio.
    wire [2:0] pre_ratio = (prescale < ccd_pkg::PRESCALE_MIN || prescale > ccd_pkg::PRESCALE_MAX)
        ? ccd_pkg::PRESCALE_MIN : prescale;
    wire [2:0] pre_half = {1'b0, pre_ratio[2:1]};
    wire [2:0] next_phase = (phase >= pre_ratio - 3'h1) ? 3'h0 : phase + 3'h1;

    // The strobes below are the one clock all single-stage and first-stage counts run on.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase <= 3'h0;
            base_rise <= 1'b0;
            base_fall <= 1'b0;
            base_level <= 1'b0;
        end else begin
            phase <= next_phase;
            base_rise <= next_phase == 3'h0;
            base_fall <= next_phase == pre_half;
            base_level <= next_phase < pre_half;
        end
    end

    // Stage strobes: 0..2 single channels, then stage pairs for channels 3 and 4.
    logic [6:0] s_rise;
    logic [6:0] s_fall;
    logic [6:0] s_lvl;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_single
            localparam int B = gi * ccd_pkg::SLOTS_PER_SINGLE;
            wire [7:0] cnts = cfg[B];
            wire [7:0] boff = cfg[B + 1];
            wire [7:0] duty = cfg[B + 2];
            wire [3:0] m = cnts[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB];
            wire [3:0] po = boff[ccd_pkg::OFFSET_MSB:ccd_pkg::OFFSET_LSB];
            wire start_high_sel = boff[ccd_pkg::START_HIGH_BIT];
            wire [4:0] dly = start_high_sel ? 5'(po) + 5'(m) + 5'h01 : 5'(po);
            ccd_stage u_stage (
                .sys_clk(sys_clk),
                .rst(rst),
                .sync(sync_pulse),
                .in_rise(base_rise),
                .in_fall(base_fall),
                .in_level(base_level),
                .bypass(boff[ccd_pkg::BYPASS_BIT]),
                .duty_fix_disable(duty[ccd_pkg::DUTY_FIX_DISABLE_BIT]),
                .low_cnt(m),
                .high_cnt(cnts[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
                .delay(dly),
                .out_rise(s_rise[gi]),
                .out_fall(s_fall[gi]),
                .out_level(s_lvl[gi])
            );
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    out_clk_a[gi] <= 1'b0;
                end else begin
                    out_clk_a[gi] <= duty[ccd_pkg::DIRECT_OUT_BIT] ? base_level : s_lvl[gi];
                end
            end
            a_offset_code: assert property (@(posedge sys_clk) disable iff (rst)
                dly == (({start_high_sel, po} < 5'h10) ? {start_high_sel, po}
                : 5'({start_high_sel, po} - 5'h10) + 5'(m) + 5'h01))
                else $error("offset code mapped wrongly");
            a_direct_out: assert property (@(posedge sys_clk) disable iff (rst)
                duty[ccd_pkg::DIRECT_OUT_BIT] |=> out_clk_a[gi] == $past(base_level))
                else $error("direct output does not follow source clock");
        end

        for (gi = 0; gi < 2; gi++) begin : g_cascade
            localparam int B = ccd_pkg::SLOT_CASCADE_BASE + gi * ccd_pkg::SLOTS_PER_CASCADE;
            localparam int S1 = 3 + 2 * gi;
            localparam int S2 = 4 + 2 * gi;
            wire [7:0] c1 = cfg[B];
            wire [7:0] c2 = cfg[B + 1];
            wire [7:0] byp = cfg[B + 2];
            // One disable bit steers both stages of the channel.
            wire dcc_off = cfg[B + 3][ccd_pkg::DUTY_FIX_DISABLE_BIT];
            // Stage two divides stage one's output, so ratios multiply.
            ccd_stage u_first (
                .sys_clk(sys_clk),
                .rst(rst),
                .sync(sync_pulse),
                .in_rise(base_rise),
                .in_fall(base_fall),
                .in_level(base_level),
                .bypass(byp[ccd_pkg::STAGE1_BYPASS_BIT]),
                .duty_fix_disable(dcc_off),
                .low_cnt(c1[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]),
                .high_cnt(c1[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
                .delay(5'h00),
                .out_rise(s_rise[S1]),
                .out_fall(s_fall[S1]),
                .out_level(s_lvl[S1])
            );
            ccd_stage u_second (
                .sys_clk(sys_clk),
                .rst(rst),
                .sync(sync_pulse),
                .in_rise(s_rise[S1]),
                .in_fall(s_fall[S1]),
                .in_level(s_lvl[S1]),
                .bypass(byp[ccd_pkg::STAGE2_BYPASS_BIT]),
                .duty_fix_disable(dcc_off),
                .low_cnt(c2[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]),
                .high_cnt(c2[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
                .delay(5'h00),
                .out_rise(s_rise[S2]),
                .out_fall(s_fall[S2]),
                .out_level(s_lvl[S2])
            );
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    out_clk_a[3 + gi] <= 1'b0;
                    out_clk_b[gi] <= 1'b0;
                end else begin
                    out_clk_a[3 + gi] <= s_lvl[S2];
                    out_clk_b[gi] <= b_en[gi] & s_lvl[S2];
                end
            end
            // The second stage only takes a new bypass setting at a sync, so the
            // live register bit cannot tell whether the stage is bypassed yet.
            logic tail_bypassed;
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    tail_bypassed <= ccd_pkg::REG_RESET[ccd_pkg::STAGE2_BYPASS_BIT];
                end else if (sync_pulse) begin
                    tail_bypassed <= byp[ccd_pkg::STAGE2_BYPASS_BIT];
                end
            end
            a_b_disabled: assert property (@(posedge sys_clk) disable iff (rst)
                !b_en[gi] |=> !out_clk_b[gi])
                else $error("disabled B output toggles");
            a_cascade_feed: assert property (@(posedge sys_clk) disable iff (rst)
                (tail_bypassed && !sync_pulse)[*2]
                |=> s_lvl[S2] == $past(s_lvl[S1]))
                else $error("bypassed second stage does not follow first");
        end
    endgenerate

    a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
        (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_pre_spacing: assert property (@(posedge sys_clk) disable iff (rst)
        base_rise |=> !base_rise)
        else $error("pre-divider strobes back to back");

endmodule

// >>> verif/tb_ccd_top.sv
// Self-checking bench for the channel clock dividers, driven over Avalon-MM.
// Assumes the divider outputs are registered levels sampled on sys_clk.
module tb_ccd_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] out_clk_a;
    logic [1:0] out_clk_b;
    wire logic [6:0] outs = {out_clk_b, out_clk_a};
    int miscompares = 0;
    int check_count = 0;
    int n;
    int s;
    always #50 sys_clk = ~sys_clk;
    ccd_top u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .out_clk_a(out_clk_a), .out_clk_b(out_clk_b));
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic guard(input int k);
        if (k > 4000) begin
            miscompares++;
            $display("ERROR %0t wait ran out", $time);
            summarize();
        end
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %0h expected %0h", $time, g, e);
        end
    endtask
    // Requests are held until the edge that samples waitrequest low.
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int k;
        k = 0;
        @(posedge sys_clk);
        avs_address <= {a, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
            k++;
            guard(k);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, e});
    endtask
    task automatic tick(input int b, input logic v);
        while (outs[b] !== v) begin
            @(posedge sys_clk);
            n++;
            guard(n);
        end
    endtask
    // The first period after a reload is skipped, as it may be partial.
    task automatic meas(input int b, input logic [15:0] eh, input logic [15:0] el);
        n = 0;
        tick(b, 1'b0);
        tick(b, 1'b1);
        tick(b, 1'b0);
        tick(b, 1'b1);
        s = n;
        tick(b, 1'b0);
        chk(16'(n - s), eh);
        s = n;
        tick(b, 1'b1);
        chk(16'(n - s), el);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < ccd_pkg::NUM_REGS; i++) begin
            rd(ccd_pkg::REG_IDX[i], 8'h00);
        end
        rd(10'h1a9, 8'h02);
        rd(10'h1aa, 8'h00);
        rd(10'h1ff, 8'h00);
        wr(10'h191, 8'h9f);
        rd(10'h191, 8'h9f);
        $display("test registers done");
        wr(10'h191, 8'h00);
        wr(10'h190, 8'h12);
        wr(10'h192, 8'h01);
        wr(10'h1a8, 8'h01);
        meas(0, 16'h0006, 16'h0004);
        wr(10'h190, 8'h77);
        meas(0, 16'h0006, 16'h0004);
        wr(10'h190, 8'h21);
        wr(10'h192, 8'h00);
        wr(10'h1a8, 8'h01);
        meas(0, 16'h0005, 16'h0005);
        wr(10'h194, 8'h80);
        wr(10'h195, 8'h01);
        wr(10'h1a8, 8'h01);
        meas(1, 16'h0001, 16'h0001);
        wr(10'h1a9, 8'h03);
        wr(10'h1a8, 8'h01);
        meas(1, 16'h0001, 16'h0002);
        wr(10'h1a9, 8'h02);
        wr(10'h196, 8'hff);
        wr(10'h198, 8'h01);
        wr(10'h1a8, 8'h01);
        meas(2, 16'h0020, 16'h0020);
        wr(10'h198, 8'h03);
        wr(10'h1a8, 8'h01);
        meas(2, 16'h0001, 16'h0001);
        wr(10'h19b, 8'h10);
        wr(10'h19d, 8'h01);
        wr(10'h1a8, 8'h01);
        meas(3, 16'h0004, 16'h0008);
        chk(16'(out_clk_b), 16'h0000);
        wr(10'h1aa, 8'h01);
        meas(5, 16'h0004, 16'h0008);
        wr(10'h19c, 8'h20);
        wr(10'h1a8, 8'h01);
        meas(3, 16'h0002, 16'h0002);
        wr(10'h1a0, 8'h21);
        wr(10'h1a8, 8'h01);
        meas(4, 16'h000a, 16'h000a);
        wr(10'h1a2, 8'h01);
        wr(10'h1a8, 8'h01);
        meas(4, 16'h0008, 16'h000c);
        wr(10'h1aa, 8'h03);
        meas(6, 16'h0008, 16'h000c);
        wr(10'h1a1, 8'h30);
        wr(10'h1a8, 8'h01);
        meas(4, 16'h0001, 16'h0001);
        $display("test dividers done");
        wr(10'h190, 8'h77);
        wr(10'h192, 8'h01);
        wr(10'h193, 8'h77);
        for (int i = 0; i < 2; i++) begin
            wr(10'h194, (i == 0) ? 8'h03 : 8'h12);
            wr(10'h1a8, 8'h01);
            meas(0, 16'h0010, 16'h0010);
            s = n;
            tick(1, 1'b0);
            tick(1, 1'b1);
            chk(16'(n - s), (i == 0) ? 16'h0006 : 16'h0014);
        end
        $display("test phase done");
        summarize();
    end
endmodule
